//--- tar_consts.svh
// Offsets, field positions, reset values and timing counts of the touch result block
// Assumes inclusion by bare name from the design modules
// How it works
// - Result registers read-only, zero after reset
// - Each conversion lands in its input's register
// - Results right-justified, bits fifteen to twelve zero
// - Control read bits 15 and 14 return status, not written value
// - Read bit fifteen shows pen contact
// - Written bit fifteen selects host or sequencer
// - Read bit fourteen is one when idle
// - Writing one to bit fourteen aborts, powers down
// - Scan field selects measurement; 0001 repeats position (only 0001 is decoded here, other codes start nothing)
// - Width field: 00/11 twelve, 01 eight, 10 ten
`ifndef TAR_CONSTS_SVH
`define TAR_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define TAR_OFS_CTRL     8'h00
`define TAR_OFS_RES_BASE 8'h20
`define TAR_OFS_IRQ_STAT 8'h04
`define TAR_OFS_IRQ_EN   8'h08
`define TAR_OFS_IRQ_CLR  8'h0c
`define TAR_OFS_START    8'h10

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define TAR_BIT_PEN      15
`define TAR_BIT_HALT     14
`define TAR_SCAN_HI      13
`define TAR_SCAN_LO      10
`define TAR_WID_HI       9
`define TAR_WID_LO       8
`define TAR_RES_MSB      11
`define TAR_RESULT_RST   16'h0000
`define TAR_SCAN_NONE    4'h0
`define TAR_SCAN_XY      4'h1
`define TAR_NUM_RES      9

// ----------------------------------------------------------------------
// Timing: one conversion takes a fixed time
// ----------------------------------------------------------------------
`define TAR_CONV_NS      8000
`define TAR_CLK_NS       10
`define TAR_CONV_CYC     (`TAR_CONV_NS / `TAR_CLK_NS)

`endif

//--- tar_pkg.sv
// Types shared by the touch result block
// Assumes tar_consts.svh is on the include path
package tar_pkg;
    // Result register index, one per measured input
    typedef enum logic [3:0] {
        TAR_IN_X, TAR_IN_Y, TAR_IN_P1, TAR_IN_P2, TAR_IN_SUP,
        TAR_IN_SP1, TAR_IN_SP2, TAR_IN_TH1, TAR_IN_TH2
    } tar_input_t;

    // One finished sample from the converter
    typedef struct packed {
        logic       valid;
        tar_input_t sel;
        logic [11:0] code;
    } tar_sample_t;

    // Request to the converter core
    typedef struct packed {
        logic       start;
        tar_input_t sel;
        logic [1:0] width;
    } tar_conv_req_t;
endpackage : tar_pkg

//--- tar_converter.sv
// Converter timing model: takes a request, counts the conversion time, returns a
// sample shaped to the chosen width. Assumes analog code arrives on sample_in.
`include "tar_consts.svh"
module tar_converter #(
    parameter int CONV_CYC = `TAR_CONV_CYC
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rstn,
    input  wire tar_pkg::tar_conv_req_t req,
    input  wire logic                   abort,
    input  wire logic [11:0]            sample_in,
    output logic                        busy,
    output tar_pkg::tar_sample_t        result
);
    logic [15:0]        cnt_q;
    tar_pkg::tar_input_t sel_q;
    logic [1:0]         wid_q;

    // ------------------------------------------------------------------
    // Conversion counter; abort kills it at once
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            busy  <= 1'b0;
            cnt_q <= 16'h0000;
            sel_q <= tar_pkg::TAR_IN_X;
            wid_q <= 2'h0;
        end else if (abort) begin
            busy  <= 1'b0;
            cnt_q <= 16'h0000;
        end else if (!busy && req.start) begin
            busy  <= 1'b1;
            cnt_q <= 16'(CONV_CYC - 1);
            sel_q <= req.sel;
            wid_q <= req.width;
        end else if (busy) begin
            if (cnt_q == 16'h0000) begin
                busy <= 1'b0;
            end else begin
                cnt_q <= cnt_q - 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Finished sample, low bits dropped for narrow widths
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            result <= '0;
        end else begin
            result.valid <= busy && !abort && cnt_q == 16'h0000;
            result.sel   <= sel_q;
            case (wid_q)
                2'h1:    result.code <= {4'h0, sample_in[11:4]};
                2'h2:    result.code <= {2'h0, sample_in[11:2]};
                default: result.code <= sample_in;
            endcase
        end
    end
endmodule : tar_converter

//--- tar_touch_result.sv
// Touch converter result and control registers behind an AXI4-Lite slave
// Assumes a single 100 MHz clock and pen and sample inputs synchronous to it
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`include "tar_consts.svh"
module tar_touch_result #(
    parameter int CONV_CYC = `TAR_CONV_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        pen_down,
    input  wire logic [11:0] sample_in,
    output logic [3:0]       sample_select,
    output logic             converter_power,
    output logic             irq
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [1:0] { SEQ_IDLE, SEQ_X, SEQ_Y } tar_seq_t;

    logic [15:0]           res_q [`TAR_NUM_RES];
    logic                  seq_sel_q;      // written bit 15
    logic                  halt_q;         // written bit 14
    logic [3:0]            scan_selection_q;
    logic [1:0]            conversion_width_select_q;
    logic [1:0]            irq_stat_q;
    logic [1:0]            irq_en_q;
    tar_seq_t              seq_q;
    logic                  aw_got_q, w_got_q;
    logic [7:0]            awaddr_q;
    logic [31:0]           wdata_q;
    logic [3:0]            wstrb_q;
    logic                  conv_busy;
    tar_pkg::tar_sample_t  sample;
    tar_pkg::tar_conv_req_t req;
    logic                  wr_fire;
    logic                  host_start;
    logic [3:0]            host_sel;
    logic [31:0]           rd_d;
    logic [15:0]           ctrl_read;
    logic                  ok_wr;

    // ------------------------------------------------------------------
    // Write channel: address and data taken in either order
    // ------------------------------------------------------------------
    assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
    assign wr_fire       = aw_got_q && w_got_q && !s_axi_bvalid;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_got_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_got_q <= 1'b0;
            end
        end
    end

    // Response: OKAY for mapped offsets except IRQ status, SLVERR otherwise
    always_comb begin
        ok_wr = (awaddr_q == `TAR_OFS_CTRL) || (awaddr_q == `TAR_OFS_IRQ_EN)
             || (awaddr_q == `TAR_OFS_IRQ_CLR) || (awaddr_q == `TAR_OFS_START)
             || (awaddr_q >= `TAR_OFS_RES_BASE
                 && awaddr_q < 8'(`TAR_OFS_RES_BASE + 4 * `TAR_NUM_RES));
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= ok_wr ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Control register write; result offsets accept and drop the data
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            seq_sel_q                 <= 1'b0;   // host-driven after reset
            halt_q                    <= 1'b0;
            scan_selection_q          <= `TAR_SCAN_NONE;
            conversion_width_select_q <= 2'h0;
        end else if (wr_fire && awaddr_q == `TAR_OFS_CTRL) begin
            if (wstrb_q[1]) begin
                seq_sel_q                 <= wdata_q[`TAR_BIT_PEN];
                halt_q                    <= wdata_q[`TAR_BIT_HALT];
                scan_selection_q          <= wdata_q[`TAR_SCAN_HI:`TAR_SCAN_LO];
                conversion_width_select_q <= wdata_q[`TAR_WID_HI:`TAR_WID_LO];
            end
        end
    end

    // One-shot host start: low bits give the input index
    assign host_start = wr_fire && awaddr_q == `TAR_OFS_START && wstrb_q[0]
                        && !seq_sel_q && !halt_q;
    assign host_sel   = wdata_q[3:0];

    // ------------------------------------------------------------------
    // Position sequencer: repeats X then Y while pen is down
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            seq_q <= SEQ_IDLE;
        end else begin
            case (seq_q)
                SEQ_IDLE: begin
                    if (seq_sel_q && !halt_q && pen_down && scan_selection_q == `TAR_SCAN_XY && !conv_busy) begin
                        seq_q <= SEQ_X;
                    end
                end
                SEQ_X: begin
                    if (halt_q || !pen_down || !seq_sel_q) begin
                        seq_q <= SEQ_IDLE;
                    end else if (sample.valid) begin
                        seq_q <= SEQ_Y;
                    end
                end
                SEQ_Y: begin
                    if (halt_q || !pen_down || !seq_sel_q) begin
                        seq_q <= SEQ_IDLE;
                    end else if (sample.valid) begin
                        seq_q <= SEQ_X;
                    end
                end
                default: seq_q <= SEQ_IDLE;
            endcase
        end
    end

    // Request mux: sequencer owns the converter when selected
    always_comb begin
        req.width = conversion_width_select_q;
        if (seq_q != SEQ_IDLE) begin
            req.start = !conv_busy && !sample.valid;
            req.sel   = (seq_q == SEQ_X) ? tar_pkg::TAR_IN_X : tar_pkg::TAR_IN_Y;
        end else begin
            req.start = host_start && host_sel < 4'(`TAR_NUM_RES);
            req.sel   = tar_pkg::tar_input_t'(host_sel);
        end
    end

    tar_converter #(
        .CONV_CYC (CONV_CYC)
    ) u_conv (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .req       (req),
        .abort     (halt_q),
        .sample_in (sample_in),
        .busy      (conv_busy),
        .result    (sample)
    );

    // ------------------------------------------------------------------
    // Result store: only the converter writes these
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < `TAR_NUM_RES; i++) begin
                res_q[i] <= `TAR_RESULT_RST;
            end
        end else if (sample.valid) begin
            res_q[sample.sel] <= {4'h0, sample.code};
        end
    end

    // ------------------------------------------------------------------
    // Interrupts: bit0 result done, bit1 pen touched; set beats clear
    // ------------------------------------------------------------------
    logic pen_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pen_q      <= 1'b0;
            irq_stat_q <= 2'h0;
            irq_en_q   <= 2'h0;
        end else begin
            pen_q <= pen_down;
            if (wr_fire && awaddr_q == `TAR_OFS_IRQ_EN && wstrb_q[0]) begin
                irq_en_q <= wdata_q[1:0];
            end
            irq_stat_q <= (irq_stat_q
                           & ~((wr_fire && awaddr_q == `TAR_OFS_IRQ_CLR && wstrb_q[0]) ? wdata_q[1:0] : 2'h0))
                          | {pen_down && !pen_q, sample.valid};
        end
    end
    assign irq = |(irq_stat_q & irq_en_q);

    // ------------------------------------------------------------------
    // Read channel: one outstanding read, answer one cycle after address
    // ------------------------------------------------------------------
    assign ctrl_read = {pen_down, !conv_busy, scan_selection_q,
                        conversion_width_select_q, 8'h00};
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rd_d = 32'h0000_0000;
        if (s_axi_araddr == `TAR_OFS_CTRL) begin
            rd_d = {16'h0000, ctrl_read};
        end else if (s_axi_araddr == `TAR_OFS_IRQ_STAT) begin
            rd_d = {30'h0, irq_stat_q};
        end else if (s_axi_araddr == `TAR_OFS_IRQ_EN) begin
            rd_d = {30'h0, irq_en_q};
        end else if (s_axi_araddr >= `TAR_OFS_RES_BASE
                     && s_axi_araddr < 8'(`TAR_OFS_RES_BASE + 4 * `TAR_NUM_RES)) begin
            rd_d = {16'h0000, res_q[4'((s_axi_araddr - `TAR_OFS_RES_BASE) >> 2)]};
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_d;
            s_axi_rresp  <= (s_axi_araddr == `TAR_OFS_CTRL || s_axi_araddr == `TAR_OFS_IRQ_STAT
                             || s_axi_araddr == `TAR_OFS_IRQ_EN || s_axi_araddr == `TAR_OFS_IRQ_CLR
                             || s_axi_araddr == `TAR_OFS_START
                             || (s_axi_araddr >= `TAR_OFS_RES_BASE
                                 && s_axi_araddr < 8'(`TAR_OFS_RES_BASE + 4 * `TAR_NUM_RES)))
                            ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Converter pins: powered down by the halt bit
    assign converter_power = !halt_q;

    // Analog select held for the whole conversion; a later bus write or a
    // sequencer stop must not move the input that is being sampled
    logic [3:0] sel_hold_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sel_hold_q <= 4'h0;
        end else if (req.start && !conv_busy && !halt_q) begin
            sel_hold_q <= req.sel;
        end
    end
    assign sample_select   = conv_busy ? sel_hold_q : req.sel;
endmodule : tar_touch_result

//--- tar_touch_result_properties.sv
// Port-level checks of the touch result block
// Assumes binding onto tar_touch_result and a single clock domain
module tar_touch_result_props #(
    parameter int CONV_CYC = 4
) (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        pen_down,
    input wire logic        converter_power,
    input wire logic        irq
);
    logic [7:0]  rd_a_q;
    logic [7:0]  wr_a_q;
    logic [31:0] wd_q;
    logic [3:0]  ws_q;
    // ----
    // Remember what each transfer addressed, so answers can be judged
    // ----
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_a_q <= 8'h00;
            wr_a_q <= 8'h00;
            wd_q   <= 32'h0;
            ws_q   <= 4'h0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) rd_a_q <= s_axi_araddr;
            if (s_axi_awvalid && s_axi_awready) wr_a_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata;
            if (s_axi_wvalid && s_axi_wready) ws_q <= s_axi_wstrb;
        end
    end
    wire rd_res = (rd_a_q >= 8'h20) && (rd_a_q <= 8'h40);
    wire wr_res = (wr_a_q >= 8'h20) && (wr_a_q <= 8'h40);
    wire ctl_wr = (wr_a_q == 8'h00) && ws_q[1];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer not one cycle after address");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped before taken");
    write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped before taken");
    result_top_zero_a: assert property ($rose(s_axi_rvalid) && rd_res |-> s_axi_rdata[31:12] == 20'h0)
        else $error("result upper bits not zero");
    pen_status_a: assert property ($rose(s_axi_rvalid) && rd_a_q == 8'h00 |-> s_axi_rdata[15] == $past(pen_down))
        else $error("control read does not show pen contact");
    halt_idle_a: assert property ($rose(s_axi_rvalid) && rd_a_q == 8'h00 && !$past(converter_power, 2)
        && !$past(converter_power) |-> s_axi_rdata[14]) else $error("halted converter reads busy");
    halt_power_a: assert property ($rose(s_axi_bvalid) && ctl_wr && wd_q[14] |-> ##[0:2] !converter_power)
        else $error("halt write did not power down");
    wake_power_a: assert property ($rose(s_axi_bvalid) && ctl_wr && !wd_q[14] |-> ##[0:2] converter_power)
        else $error("normal mode write left converter off");
    result_write_ok_a: assert property ($rose(s_axi_bvalid) && wr_res |-> s_axi_bresp == 2'b00)
        else $error("result write not answered okay");
    unmapped_read_a: assert property ($rose(s_axi_rvalid) && rd_a_q == 8'h44 |-> s_axi_rresp == 2'b10)
        else $error("unmapped read not refused");
    cover property ($rose(irq));
    cover property ($fell(converter_power));
    cover property ($rose(s_axi_rvalid) && rd_a_q == 8'h00 && s_axi_rdata[15]);
endmodule : tar_touch_result_props

bind tar_touch_result tar_touch_result_props #(.CONV_CYC(CONV_CYC)) u_props (
    .sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pen_down, .converter_power, .irq
);

//--- tar_panel_model.sv
// Analog side of the converter: one distinct level per measured input
// Assumes the bench sets the seed level before each conversion
module tar_panel_model (
    input wire logic [3:0]  sample_select,
    input wire logic [11:0] seed,
    input wire logic        powered,
    output logic [11:0]     sample_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Distinct codes expose a wrong select; powered off shows a foreign level
    always_comb sample_in = powered ? seed + 12'(sample_select) * 12'h123 : ~seed;
endmodule : tar_panel_model

//--- tar_touch_result_test.sv
// Self-checking bench of the touch result block
// Assumes the design, the panel model and the bound checker are compiled first
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin errors++; \
    $display("unexpected %s exp %h got %h", nm, ex, got); end end
module tar_touch_result_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CONV = 16;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, d;
    logic        pen_down = 1'b0, converter_power, irq;
    logic [11:0] sample_in, seed = 12'h000;
    logic [3:0]  sample_select;
    int          errors = 0, n_compared = 0, i;
    int          res[9];

    tar_touch_result #(.CONV_CYC(CONV)) u_dut (
        .sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .pen_down, .sample_in, .sample_select, .converter_power, .irq
    );
    tar_panel_model u_panel (.sample_select, .seed, .powered(converter_power), .sample_in);

    always #5 sys_clk = ~sys_clk;

    // ----
    // Bus tasks: each starts one edge on, so no signal is driven twice in a step
    // ----
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
        int k = 0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            k++;
        end while (!s_axi_bvalid && k < 50);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (k >= 50) begin errors++; final_report(); end
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int k = 0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            k++;
        end while (!s_axi_rvalid && k < 50);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (k >= 50) begin errors++; final_report(); end
    endtask : rd
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        `CHK("read data", e, d)
        `CHK("read resp", 2'b00, r)
    endtask : rchk
    task automatic wait_irq();
        int k;
        for (k = 0; k < 300 && irq !== 1'b1; k++) @(posedge sys_clk);
        `CHK("irq", 1'b1, irq)
        if (k >= 300) final_report();
    endtask : wait_irq
    // Narrow widths keep the top bits of the code, right-justified
    function automatic logic [31:0] shape(input logic [11:0] c, input logic [1:0] w);
        case (w)
            2'b01: return {24'h0, c[11:4]};
            2'b10: return {22'h0, c[11:2]};
            default: return {20'h0, c};
        endcase
    endfunction : shape
    task automatic final_report();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report

    // ----
    // Main sequence
    // ----
    initial begin
        void'($urandom(8));
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        rchk(8'h00, 32'h4000);
        for (i = 0; i < 9; i++) rchk(8'h20 + 8'(4 * i), 32'h0);
        rd(8'h44);
        `CHK("unmapped resp", 2'b10, r)
        // Every input in turn, cycling all width codes; first one with irq masked
        for (i = 0; i < 9; i++) begin
            seed <= 12'($urandom);
            wr(8'h00, 32'(i % 4) << 8, 4'h2);
            wr(8'h10, 32'(i), 4'h1);
            if (i == 0) rchk(8'h00, 32'h0000);
            if (i == 0) begin
                repeat (CONV + 6) @(posedge sys_clk);
                `CHK("masked irq", 1'b0, irq)
                wr(8'h08, 32'h1, 4'h1);
            end
            wait_irq();
            res[i] = int'(shape(seed + 12'(i) * 12'h123, 2'(i % 4)));
            rchk(8'h20 + 8'(4 * i), 32'(res[i]));
            wr(8'h0c, 32'h1, 4'h1);
            rchk(8'h04, 32'h0);
            `CHK("irq cleared", 1'b0, irq)
        end
        // Host writes to a result are answered but change nothing
        wr(8'h20, 32'hffff, 4'hf);
        `CHK("result write resp", 2'b00, r)
        rchk(8'h20, 32'(res[0]));
        // Halt: power drops, status reads idle, starts are refused
        wr(8'h00, 32'hc000, 4'h2);
        `CHK("power off", 1'b0, converter_power)
        rchk(8'h00, 32'h4000);
        wr(8'h10, 32'h1, 4'h1);
        repeat (CONV + 6) @(posedge sys_clk);
        rchk(8'h04, 32'h0);
        wr(8'h00, 32'h0, 4'h2);
        // Abort in mid-conversion leaves the old result
        seed <= 12'($urandom);
        wr(8'h10, 32'h2, 4'h1);
        wr(8'h00, 32'h4000, 4'h2);
        repeat (CONV + 6) @(posedge sys_clk);
        rchk(8'h28, 32'(res[2]));
        rchk(8'h04, 32'h0);
        wr(8'h00, 32'h0, 4'h2);
        // Sequencer scan of both positions while the pen is down
        seed <= 12'($urandom);
        wr(8'h08, 32'h3, 4'h1);
        pen_down <= 1'b1;
        wait_irq();
        rchk(8'h04, 32'h2);
        wr(8'h00, 32'h8400, 4'h2);
        rd(8'h00);
        `CHK("pen read", 1'b1, d[15])
        repeat (4 * (CONV + 4)) @(posedge sys_clk);
        wr(8'h00, 32'h0, 4'h2);
        pen_down <= 1'b0;
        repeat (CONV + 6) @(posedge sys_clk);
        rchk(8'h20, 32'(shape(seed, 2'b00)));
        rchk(8'h24, 32'(shape(seed + 12'h123, 2'b00)));
        rchk(8'h28, 32'(res[2]));
        final_report();
    end
endmodule : tar_touch_result_test
